//--- lps_cfg.svh
// Purpose: constants of the light and proximity core
// Assumes: mclk at 200 MHz
// Notes: times in ns, cycle counts derived from them
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH
`define LPS_CLK_MHZ 200
`define LPS_STEP_NS 2730000
`define LPS_PERIOD_NS 16000
`define LPS_LEDON_NS 8000
`define LPS_STEP_CYC (`LPS_STEP_NS * `LPS_CLK_MHZ / 1000)
`define LPS_PERIOD_CYC (`LPS_PERIOD_NS * `LPS_CLK_MHZ / 1000)
`define LPS_LEDON_CYC (`LPS_LEDON_NS * `LPS_CLK_MHZ / 1000)
`define LPS_ACC_MAX 16'hffff
`define LPS_STEP_MAX 16'h03ff
`define LPS_I2C_ADDR 7'h39
`define LPS_CTRL 8'h00
`define LPS_ALSSTEPS 8'h01
`define LPS_WAITTIME 8'h02
`define LPS_PULSES 8'h03
`define LPS_ALSLO 8'h04
`define LPS_ALSHI 8'h05
`define LPS_PRXLO 8'h06
`define LPS_PRXHI 8'h07
`define LPS_PERSIST 8'h08
`define LPS_STATUS 8'h09
`define LPS_BBDATA 8'h0a
`define LPS_IRDATA 8'h0b
`define LPS_PRXDATA 8'h0c
`define LPS_IRQCLR 8'h0d
`define LPS_CTRL_PON 0
`define LPS_CTRL_ALSEN 1
`define LPS_CTRL_PRXEN 2
`define LPS_CTRL_WAITEN 3
`define LPS_CTRL_IRQEN 4
`define LPS_CTRL_RST 5'h00
`define LPS_ALSSTEPS_RST 8'h00
`define LPS_WAITTIME_RST 12'h000
`define LPS_PULSES_RST 8'h01
`define LPS_LO_RST 16'h0000
`define LPS_HI_RST 16'hffff
`define LPS_PERSIST_RST 8'h00
`endif

//--- lps_pkg.sv
// Purpose: types of the light and proximity core
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package lps_pkg;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_ALS = 4'b0010, S_PROX = 4'b0100, S_WAIT = 4'b1000
  } lps_state_e;
  typedef enum logic [4:0] {
    I_IDLE = 5'b00001, I_RECV = 5'b00010, I_ACK = 5'b00100,
    I_SEND = 5'b01000, I_MACK = 5'b10000
  } lps_i2c_e;
endpackage
`default_nettype wire

//--- lps_chan_acc.sv
// Purpose: saturating accumulator of one converter channel
// Assumes: step is at most 1023 counts
// Notes: result is latched when the last step is added
`include "lps_cfg.svh"
`default_nettype none
module lps_chan_acc (
  input wire logic mclk,
  input wire logic srst,
  input wire logic addEn,
  input wire logic last,
  input wire logic abort,
  input wire logic [9:0] step,
  output logic [15:0] result
);
  logic [15:0] accReg, accNext, resReg, resNext, sat;
  logic [16:0] sum;

  always_comb begin
    sum = {1'b0, accReg} + {7'h00, step};
    sat = sum[16] ? `LPS_ACC_MAX : sum[15:0];
    accNext = accReg;
    resNext = resReg;
    if (abort) begin
      accNext = 16'h0000;
    end else if (addEn) begin
      if (last) begin
        resNext = sat;
        accNext = 16'h0000;
      end else begin
        accNext = sat;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      accReg <= 16'h0000;
      resReg <= 16'h0000;
    end else begin
      accReg <= accNext;
      resReg <= resNext;
    end
  end

  assign result = resReg;

  a_acc_step_sat: assert property (@(posedge mclk) disable iff (srst)
    addEn && !last && !abort |=> accReg >= $past(accReg) &&
      accReg - $past(accReg) <= `LPS_STEP_MAX)
    else $error("accumulator step out of range");
  a_acc_latch: assert property (@(posedge mclk) disable iff (srst)
    addEn && last && !abort |=> accReg == 16'h0000 && resReg >= $past(accReg))
    else $error("result not latched at end of conversion");
endmodule
`default_nettype wire

//--- lps_i2c_target.sv
// Purpose: two-wire serial target reaching the register port
// Assumes: serial clock up to 400 kHz, far below mclk
// Notes: first data byte is the pointer, words go low byte first
`include "lps_cfg.svh"
`default_nettype none
module lps_i2c_target import lps_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic wrStb,
  output logic rdStb,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  logic sclM, sclS, sclD, sdaM, sdaS, sdaD;
  lps_i2c_e stReg, stNext;
  logic [3:0] bitReg, bitNext;
  logic [7:0] shReg, shNext, ptrReg, ptrNext, lowReg, lowNext, curByte;
  logic [1:0] phReg, phNext;
  logic isRdReg, isRdNext, hiReg, hiNext, oeReg, oeNext;
  logic wrReg, wrNext, rdReg, rdNext, rdDly;
  logic [15:0] wdReg, wdNext, wordReg, wordNext;
  logic start, stop, sclRise, sclFall;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge mclk) begin
    sclM <= sclIn;
    sclS <= sclM;
    sclD <= sclS;
    sdaM <= sdaIn;
    sdaS <= sdaM;
    sdaD <= sdaS;
  end

  assign sclRise = sclS & ~sclD;
  assign sclFall = ~sclS & sclD;
  assign start = sclS & sclD & sdaD & ~sdaS;
  assign stop = sclS & sclD & ~sdaD & sdaS;
  assign curByte = hiReg ? wordReg[15:8] : wordReg[7:0];

  // ************************************************************
  // Protocol engine
  // ************************************************************
  always_comb begin
    stNext = stReg;
    bitNext = bitReg;
    shNext = shReg;
    ptrNext = wrReg ? ptrReg + 8'h01 : ptrReg;
    lowNext = lowReg;
    phNext = phReg;
    isRdNext = isRdReg;
    hiNext = hiReg;
    oeNext = oeReg;
    wdNext = wdReg;
    wrNext = 1'b0;
    rdNext = 1'b0;
    wordNext = rdDly ? rdata : wordReg;
    if (start) begin
      stNext = I_RECV;
      bitNext = 4'h0;
      phNext = 2'h0;
      hiNext = 1'b0;
      oeNext = 1'b0;
    end else if (stop) begin
      stNext = I_IDLE;
      oeNext = 1'b0;
    end else begin
      unique case (stReg)
        I_IDLE: begin
        end
        I_RECV: begin
          if (sclRise && bitReg != 4'h8) begin
            shNext = {shReg[6:0], sdaS};
            bitNext = bitReg + 4'h1;
          end else if (sclFall && bitReg == 4'h8) begin
            stNext = I_ACK;
            oeNext = 1'b1;
            if (phReg == 2'h0) begin
              if (shReg[7:1] != `LPS_I2C_ADDR) begin
                stNext = I_IDLE;
                oeNext = 1'b0;
              end else begin
                isRdNext = shReg[0];
                rdNext = shReg[0];
                phNext = 2'h1;
                hiNext = 1'b0;
              end
            end else if (phReg == 2'h1) begin
              ptrNext = shReg;
              phNext = 2'h2;
              hiNext = 1'b0;
            end else if (!hiReg) begin
              lowNext = shReg;
              hiNext = 1'b1;
            end else begin
              wdNext = {shReg, lowReg};
              wrNext = 1'b1;
              hiNext = 1'b0;
            end
          end
        end
        I_ACK: begin
          if (sclFall) begin
            bitNext = 4'h0;
            if (isRdReg) begin
              stNext = I_SEND;
              shNext = curByte;
              oeNext = ~curByte[7];
            end else begin
              stNext = I_RECV;
              oeNext = 1'b0;
            end
          end
        end
        I_SEND: begin
          if (sclFall) begin
            bitNext = bitReg + 4'h1;
            shNext = {shReg[6:0], 1'b0};
            oeNext = bitReg == 4'h7 ? 1'b0 : ~shReg[6];
            if (bitReg == 4'h7) begin
              stNext = I_MACK;
            end
          end
        end
        I_MACK: begin
          if (sclRise) begin
            if (sdaS) begin
              stNext = I_IDLE;
            end else begin
              hiNext = ~hiReg;
              if (hiReg) begin
                ptrNext = ptrReg + 8'h01;
                rdNext = 1'b1;
              end
            end
          end else if (sclFall) begin
            stNext = I_SEND;
            bitNext = 4'h0;
            shNext = curByte;
            oeNext = ~curByte[7];
          end
        end
        default: stNext = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stReg <= I_IDLE;
      bitReg <= 4'h0;
      shReg <= 8'h00;
      ptrReg <= 8'h00;
      lowReg <= 8'h00;
      phReg <= 2'h0;
      isRdReg <= 1'b0;
      hiReg <= 1'b0;
      oeReg <= 1'b0;
      wdReg <= 16'h0000;
      wrReg <= 1'b0;
      rdReg <= 1'b0;
      rdDly <= 1'b0;
      wordReg <= 16'h0000;
    end else begin
      stReg <= stNext;
      bitReg <= bitNext;
      shReg <= shNext;
      ptrReg <= ptrNext;
      lowReg <= lowNext;
      phReg <= phNext;
      isRdReg <= isRdNext;
      hiReg <= hiNext;
      oeReg <= oeNext;
      wdReg <= wdNext;
      wrReg <= wrNext;
      rdReg <= rdNext;
      rdDly <= rdReg;
      wordReg <= wordNext;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = oeReg;
  assign wrStb = wrReg;
  assign rdStb = rdReg;
  assign addr = ptrReg;
  assign wdata = wdReg;
endmodule
`default_nettype wire

//--- lps_core.sv
// Purpose: measurement, threshold and interrupt core of a light and proximity sensor
// Assumes: converter step samples arrive on mclk; plain register port on mclk
// Notes: serial target shares the register port, plain port has priority
//
// Notes on behaviour
// - Broadband and infrared channels are integrated together, up to 16 bits.
// - At end of conversion each channel result is copied to its data register.
// - With interrupts enabled, a threshold event holds the pin until firmware clears it.
// - A result outside the lower/upper threshold window is an interrupt condition.
// - The interrupt fires only after persistence consecutive out-of-window results.
// - Light and proximity paths have separate thresholds, persistence and counters.
// - Each proximity measurement fires a burst of 1 to 255 pulses, 16 us each.
// - Host port is a two-wire target up to 400 kHz; the bench host runs a 64 ns serial clock period.
// - The sequencer can sit in a low-power wait between measurement cycles.
// - Wait timer spans about 2.7 ms to beyond 8 seconds.
// - Each light step adds at most 1023 counts; sums saturate at 65535.
// - The LED drive is active for 8 us within each pulse period.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "lps_cfg.svh"
`default_nettype none
module lps_core import lps_pkg::*; #(
  parameter int STEP_CYC = `LPS_STEP_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [9:0] bbStep,
  input wire logic [9:0] irStep,
  input wire logic [9:0] proxStep,
  output logic ledDrvOut,
  output logic ledDrvOe,
  output logic irqPinOut,
  output logic irqPinOe,
  output logic lowPower
);
  localparam int PER_CYC = `LPS_PERIOD_CYC;
  localparam int LEDON_CYC = `LPS_LEDON_CYC;

  // Out-of-window test with persistence; returns {fire, next count}
  function automatic logic [4:0] persistStep(input logic [15:0] v, input logic [15:0] lo,
      input logic [15:0] hi, input logic [3:0] cnt, input logic [3:0] lim);
    logic out;
    logic [3:0] cn;
    out = (v < lo) || (v > hi);
    cn = !out ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
    persistStep = {out && (cn >= ((lim == 4'h0) ? 4'h1 : lim)), cn};
  endfunction

  // ************************************************************
  // Register port and serial target
  // ************************************************************
  logic i2cWr, i2cRd, plainSel, busWr, busRd;
  logic [7:0] i2cAddr, busAddr;
  logic [15:0] i2cWdata, busWd;
  logic [4:0] ctrlReg, ctrlNext;
  logic [7:0] alsStepsReg, alsStepsNext, pulsesReg, pulsesNext, persistReg, persistNext;
  logic [11:0] waitReg, waitNext;
  logic [15:0] alsLoReg, alsLoNext, alsHiReg, alsHiNext, prxLoReg, prxLoNext;
  logic [15:0] prxHiReg, prxHiNext, rdReg, rdNext;
  logic [15:0] bbData, irData, prxData;
  logic alsIrqReg, alsIrqNext, prxIrqReg, prxIrqNext;
  logic alsValidReg, prxValidReg;
  logic clrAls, clrPrx;

  lps_i2c_target u_i2c (
    .mclk(mclk),
    .srst(srst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .wrStb(i2cWr),
    .rdStb(i2cRd),
    .addr(i2cAddr),
    .wdata(i2cWdata),
    .rdata(rdReg)
  );

  assign plainSel = regWr | regRd;
  assign busAddr = plainSel ? regAddr : i2cAddr;
  assign busWd = plainSel ? regWdata : i2cWdata;
  assign busWr = plainSel ? regWr : i2cWr;
  assign busRd = plainSel ? regRd : i2cRd;
  assign clrAls = busWr && busAddr == `LPS_IRQCLR && busWd[0];
  assign clrPrx = busWr && busAddr == `LPS_IRQCLR && busWd[1];

  always_comb begin
    ctrlNext = ctrlReg;
    alsStepsNext = alsStepsReg;
    waitNext = waitReg;
    pulsesNext = pulsesReg;
    alsLoNext = alsLoReg;
    alsHiNext = alsHiReg;
    prxLoNext = prxLoReg;
    prxHiNext = prxHiReg;
    persistNext = persistReg;
    rdNext = rdReg;
    if (busWr) begin
      case (busAddr)
        `LPS_CTRL: ctrlNext = busWd[4:0];
        `LPS_ALSSTEPS: alsStepsNext = busWd[7:0];
        `LPS_WAITTIME: waitNext = busWd[11:0];
        `LPS_PULSES: pulsesNext = busWd[7:0];
        `LPS_ALSLO: alsLoNext = busWd;
        `LPS_ALSHI: alsHiNext = busWd;
        `LPS_PRXLO: prxLoNext = busWd;
        `LPS_PRXHI: prxHiNext = busWd;
        `LPS_PERSIST: persistNext = busWd[7:0];
        default: begin
        end
      endcase
    end
    if (busRd) begin
      case (busAddr)
        `LPS_CTRL: rdNext = {11'h000, ctrlReg};
        `LPS_ALSSTEPS: rdNext = {8'h00, alsStepsReg};
        `LPS_WAITTIME: rdNext = {4'h0, waitReg};
        `LPS_PULSES: rdNext = {8'h00, pulsesReg};
        `LPS_ALSLO: rdNext = alsLoReg;
        `LPS_ALSHI: rdNext = alsHiReg;
        `LPS_PRXLO: rdNext = prxLoReg;
        `LPS_PRXHI: rdNext = prxHiReg;
        `LPS_PERSIST: rdNext = {8'h00, persistReg};
        `LPS_STATUS: rdNext = {12'h000, prxIrqReg, alsIrqReg, prxValidReg, alsValidReg};
        `LPS_BBDATA: rdNext = bbData;
        `LPS_IRDATA: rdNext = irData;
        `LPS_PRXDATA: rdNext = prxData;
        default: rdNext = 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // Measurement sequencer
  // ************************************************************
  lps_state_e stReg, stNext, afterAls, afterPrx;
  logic [19:0] cycReg, cycNext;
  logic [11:0] unitReg, unitNext;
  logic [7:0] pulsesEff;
  logic pon, stepEnd, perEnd, alsAdd, alsLast, prxAdd, prxLast, ledReg, ledNext;
  logic alsEvalReg, prxEvalReg;

  assign pon = ctrlReg[`LPS_CTRL_PON];
  assign pulsesEff = (pulsesReg == 8'h00) ? 8'h01 : pulsesReg;
  assign stepEnd = cycReg == 20'(STEP_CYC - 1);
  assign perEnd = cycReg == 20'(PER_CYC - 1);
  assign afterPrx = ctrlReg[`LPS_CTRL_WAITEN] ? S_WAIT : S_IDLE;
  assign afterAls = ctrlReg[`LPS_CTRL_PRXEN] ? S_PROX : afterPrx;

  always_comb begin
    stNext = stReg;
    cycNext = cycReg + 20'h00001;
    unitNext = unitReg;
    alsAdd = 1'b0;
    alsLast = 1'b0;
    prxAdd = 1'b0;
    prxLast = 1'b0;
    if (!pon) begin
      stNext = S_IDLE;
      cycNext = 20'h00000;
      unitNext = 12'h000;
    end else begin
      unique case (stReg)
        S_IDLE: begin
          stNext = ctrlReg[`LPS_CTRL_ALSEN] ? S_ALS : afterAls;
          cycNext = 20'h00000;
          unitNext = 12'h000;
        end
        S_ALS: begin
          if (stepEnd) begin
            cycNext = 20'h00000;
            alsAdd = 1'b1;
            unitNext = unitReg + 12'h001;
            if (unitReg == {4'h0, alsStepsReg}) begin
              alsLast = 1'b1;
              unitNext = 12'h000;
              stNext = afterAls;
            end
          end
        end
        S_PROX: begin
          if (perEnd) begin
            cycNext = 20'h00000;
            prxAdd = 1'b1;
            unitNext = unitReg + 12'h001;
            if (unitReg == {4'h0, pulsesEff - 8'h01}) begin
              prxLast = 1'b1;
              unitNext = 12'h000;
              stNext = afterPrx;
            end
          end
        end
        S_WAIT: begin
          if (stepEnd) begin
            cycNext = 20'h00000;
            unitNext = unitReg + 12'h001;
            if (unitReg == waitReg) begin
              unitNext = 12'h000;
              stNext = S_IDLE;
            end
          end
        end
      endcase
    end
    ledNext = stNext == S_PROX && cycNext < 20'(LEDON_CYC);
  end

  lps_chan_acc u_bb (
    .mclk(mclk),
    .srst(srst),
    .addEn(alsAdd),
    .last(alsLast),
    .abort(!pon),
    .step(bbStep),
    .result(bbData)
  );

  lps_chan_acc u_ir (
    .mclk(mclk),
    .srst(srst),
    .addEn(alsAdd),
    .last(alsLast),
    .abort(!pon),
    .step(irStep),
    .result(irData)
  );

  lps_chan_acc u_prx (
    .mclk(mclk),
    .srst(srst),
    .addEn(prxAdd),
    .last(prxLast),
    .abort(!pon),
    .step(proxStep),
    .result(prxData)
  );

  // ************************************************************
  // Threshold, persistence and interrupt flags
  // ************************************************************
  logic [3:0] alsCntReg, alsCntNext, prxCntReg, prxCntNext;
  logic [4:0] alsEval, prxEval;

  always_comb begin
    alsEval = persistStep(bbData, alsLoReg, alsHiReg, alsCntReg, persistReg[3:0]);
    prxEval = persistStep(prxData, prxLoReg, prxHiReg, prxCntReg, persistReg[7:4]);
    alsCntNext = alsEvalReg ? alsEval[3:0] : (clrAls ? 4'h0 : alsCntReg);
    prxCntNext = prxEvalReg ? prxEval[3:0] : (clrPrx ? 4'h0 : prxCntReg);
    alsIrqNext = (alsEvalReg && alsEval[4]) || (alsIrqReg && !clrAls);
    prxIrqNext = (prxEvalReg && prxEval[4]) || (prxIrqReg && !clrPrx);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlReg <= `LPS_CTRL_RST;
      alsStepsReg <= `LPS_ALSSTEPS_RST;
      waitReg <= `LPS_WAITTIME_RST;
      pulsesReg <= `LPS_PULSES_RST;
      alsLoReg <= `LPS_LO_RST;
      alsHiReg <= `LPS_HI_RST;
      prxLoReg <= `LPS_LO_RST;
      prxHiReg <= `LPS_HI_RST;
      persistReg <= `LPS_PERSIST_RST;
      rdReg <= 16'h0000;
      stReg <= S_IDLE;
      cycReg <= 20'h00000;
      unitReg <= 12'h000;
      ledReg <= 1'b0;
      alsEvalReg <= 1'b0;
      prxEvalReg <= 1'b0;
      alsValidReg <= 1'b0;
      prxValidReg <= 1'b0;
      alsCntReg <= 4'h0;
      prxCntReg <= 4'h0;
      alsIrqReg <= 1'b0;
      prxIrqReg <= 1'b0;
    end else begin
      ctrlReg <= ctrlNext;
      alsStepsReg <= alsStepsNext;
      waitReg <= waitNext;
      pulsesReg <= pulsesNext;
      alsLoReg <= alsLoNext;
      alsHiReg <= alsHiNext;
      prxLoReg <= prxLoNext;
      prxHiReg <= prxHiNext;
      persistReg <= persistNext;
      rdReg <= rdNext;
      stReg <= stNext;
      cycReg <= cycNext;
      unitReg <= unitNext;
      ledReg <= ledNext;
      alsEvalReg <= alsLast;
      prxEvalReg <= prxLast;
      alsValidReg <= alsValidReg | alsEvalReg;
      prxValidReg <= prxValidReg | prxEvalReg;
      alsCntReg <= alsCntNext;
      prxCntReg <= prxCntNext;
      alsIrqReg <= alsIrqNext;
      prxIrqReg <= prxIrqNext;
    end
  end

  assign regRdata = rdReg;
  assign ledDrvOut = 1'b0;
  assign ledDrvOe = ledReg;
  assign irqPinOut = 1'b0;
  assign irqPinOe = ctrlReg[`LPS_CTRL_IRQEN] & (alsIrqReg | prxIrqReg);
  assign lowPower = stReg == S_WAIT;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [11:0] ledRun;
  logic [8:0] pulseSeen;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ledRun <= 12'h000;
      pulseSeen <= 9'h000;
    end else begin
      ledRun <= ledReg ? ledRun + 12'h001 : 12'h000;
      pulseSeen <= (stNext != S_PROX) ? 9'h000 : pulseSeen + 9'(ledNext && !ledReg);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_irq_holds: assert property (alsIrqReg && !clrAls |=> alsIrqReg)
    else $error("light interrupt dropped without clear");
  a_irq_clear: assert property (clrPrx && !prxEvalReg |=> !prxIrqReg && prxCntReg == 4'h0)
    else $error("proximity clear not honoured");
  a_irq_cause: assert property ($rose(alsIrqReg) |-> $past(alsEvalReg) &&
      alsCntReg >= ((persistReg[3:0] == 4'h0) ? 4'h1 : persistReg[3:0]) &&
      (bbData < alsLoReg || bbData > alsHiReg))
    else $error("light interrupt without persistent excursion");
  a_pin_release: assert property (!alsIrqReg && !prxIrqReg ##1 !alsIrqReg && !prxIrqReg
      |-> !irqPinOe)
    else $error("interrupt pin driven with nothing pending");
  a_led_in_prox: assert property (ledDrvOe |-> stReg == S_PROX)
    else $error("LED driven outside proximity");
  a_led_width: assert property ($fell(ledDrvOe) && $past(stReg) == S_PROX && pon
      |-> ledRun == 12'(LEDON_CYC))
    else $error("LED pulse width wrong");
  a_pulse_count: assert property (prxLast |-> pulseSeen == {1'b0, pulsesEff})
    else $error("burst pulse count wrong");
  a_wait_quiet: assert property (lowPower |-> !ledDrvOe && !alsAdd && !prxAdd)
    else $error("activity during wait");
  a_conv_pair: assert property (alsLast |=> alsEvalReg ##1 alsValidReg)
    else $error("conversion end not reported");

  c_irq_fire: cover property ($rose(alsIrqReg) ##[1:20] irqPinOe);
  c_burst_done: cover property (prxLast);
  c_wait_entered: cover property ($rose(lowPower));
endmodule
`default_nettype wire

//--- lps_host_i2c.sv
// Purpose: serial host model on the far side of the core
// Assumes: 64 ns serial clock period, line pulled up
// Notes: open drain on sda, the model only ever pulls it low; scl is driven high and low
`default_nettype none
module lps_host_i2c (
  output logic scl,
  output logic sdaLow,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic startc;
    sdaLow = 1'b1;
    #32 scl = 1'b0;
  endtask
  // Eight data bits, then a ninth clock that samples the acknowledge
  task automatic bytew(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #16 sdaLow = (i >= 0) ? !b[i] : 1'b0;
      #16 scl = 1'b1;
      #16 ack = !sdaLine;
      #16 scl = 1'b0;
    end
  endtask
  task automatic stopc;
    #16 sdaLow = 1'b1;
    #16 scl = 1'b1;
    #32 sdaLow = 1'b0;
    #32;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench of the light and proximity core
// Assumes: STEP_CYC set to 20
// Notes: serial host lives in its own module
`include "lps_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata, rv;
  logic [9:0] bbStep = 10'h006;
  logic [9:0] irStep = 10'h005;
  logic [9:0] proxStep = 10'h007;
  logic scl, sdaLow, sdaLine, sdaOe, ledDrvOe, irqPinOe, lowPower, ak;
  int err_total = 0;
  int checks_done = 0;
  int c;
  assign sdaLine = !(sdaLow || sdaOe);
  always #2.5 mclk = ~mclk;
  lps_core #(.STEP_CYC(20)) uut (.mclk, .srst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .sclIn(scl), .sdaIn(sdaLine), .sdaOut(), .sdaOe, .bbStep, .irStep,
    .proxStep, .ledDrvOut(), .ledDrvOe, .irqPinOut(), .irqPinOe, .lowPower);
  lps_host_i2c host (.scl, .sdaLow, .sdaLine);
  task automatic chk(string s, logic [15:0] g, logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rst;
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask
  // Polls status until a bit of the mask is set
  task automatic wt(logic [15:0] m);
    int n;
    n = 0;
    do begin
      rd(`LPS_STATUS);
      n++;
    end while ((rv & m) === 16'h0000 && n < 3000);
    if (n >= 3000) begin
      err_total++;
      end_sim;
    end
  endtask
  // Waits for a level, then counts the cycles it stays there
  task automatic lvl(ref logic s, input logic v, output int k);
    int t;
    t = 0;
    k = 0;
    while (s !== v && t < 9000) begin
      @(posedge mclk);
      #1 t++;
    end
    while (s === v && k < 9000) begin
      @(posedge mclk);
      #1 k++;
    end
    if (t >= 9000) begin
      err_total++;
      end_sim;
    end
  endtask
  task automatic t_reset;
    rd(`LPS_PULSES);
    chk("pulses", rv, 16'h0001);
    rd(`LPS_ALSHI);
    chk("alshi", rv, 16'hffff);
    rd(8'h3f);
    chk("unmapped", rv, 16'h0000);
    chk("irq idle", 16'(irqPinOe), 16'h0000);
  endtask
  task automatic t_i2c;
    host.startc;
    host.bytew(8'h72, ak);
    chk("ack addr", 16'(ak), 16'h0001);
    host.bytew(`LPS_PERSIST, ak);
    host.bytew(8'h21, ak);
    host.bytew(8'h00, ak);
    host.stopc;
    rd(`LPS_PERSIST);
    chk("i2c write", rv, 16'h0021);
    host.startc;
    host.bytew(8'h50, ak);
    host.stopc;
    chk("nak addr", 16'(ak), 16'h0000);
  endtask
  task automatic t_irq;
    rst;
    wr(`LPS_ALSHI, 16'h0005);
    wr(`LPS_PERSIST, 16'h0002);
    wr(`LPS_CTRL, 16'h0013);
    wt(16'h0001);
    repeat (4) @(posedge mclk);
    chk("irq early", 16'(irqPinOe), 16'h0000);
    wt(16'h0004);
    chk("irq set", 16'(irqPinOe), 16'h0001);
    chk("prx flag", rv & 16'h0008, 16'h0000);
    wr(`LPS_IRQCLR, 16'h0003);
    @(posedge mclk);
    #1 chk("irq clr", 16'(irqPinOe), 16'h0000);
  endtask
  task automatic t_sat;
    rst;
    bbStep <= 10'h3ff;
    wr(`LPS_ALSSTEPS, 16'h00ff);
    wr(`LPS_CTRL, 16'h0003);
    wt(16'h0001);
    rd(`LPS_BBDATA);
    chk("bb sat", rv, 16'hffff);
    rd(`LPS_IRDATA);
    chk("ir sum", rv, 16'h0500);
  endtask
  task automatic t_prox;
    rst;
    wr(`LPS_PULSES, 16'h0002);
    wr(`LPS_CTRL, 16'h0005);
    lvl(ledDrvOe, 1'b1, c);
    chk("led on", 16'(c), 16'd1600);
    lvl(ledDrvOe, 1'b0, c);
    chk("led off", 16'(c), 16'd1600);
    wt(16'h0002);
    rd(`LPS_PRXDATA);
    chk("prx data", rv, 16'h000e);
  endtask
  task automatic t_wait;
    rst;
    wr(`LPS_CTRL, 16'h0009);
    lvl(lowPower, 1'b1, c);
    chk("wait len", 16'(c), 16'd20);
  endtask
  initial begin
    rst;
    t_reset;
    t_i2c;
    t_irq;
    t_sat;
    t_prox;
    t_wait;
    end_sim;
  end
endmodule
`default_nettype wire
